// ===== hdl/dsmw_cfg.svh
// Timing, format and field constants of the sector write encoder
`ifndef DSMW_CFG_SVH
`define DSMW_CFG_SVH

// System clock rate
`define DSMW_CLK_MHZ 200

// Bit cell times in ns: MFM cell and the plain FM cell it halves
`define DSMW_MFM_CELL_NS 2000
`define DSMW_FM_CELL_NS 4000
`define DSMW_CELL_CYC ((`DSMW_MFM_CELL_NS * `DSMW_CLK_MHZ) / 1000)

// Pre-compensation shift of a reversal
`define DSMW_PRECOMP_NS 250
`define DSMW_PRECOMP_CYC ((`DSMW_PRECOMP_NS * `DSMW_CLK_MHZ) / 1000)

// Sector layout, lengths in bytes; the flush length in cells
`define DSMW_PRE_LEN 9'd32
`define DSMW_SYNC_LEN 9'd1
`define DSMW_HDR_LEN 9'd2
`define DSMW_DATA_LEN 9'd256
`define DSMW_CRC_LEN 9'd2
`define DSMW_POST_LEN 9'd18
`define DSMW_FLUSH_CELLS 3'd2

// Fixed byte values
`define DSMW_SYNC_BYTE 8'h01
`define DSMW_FILL_BYTE 8'h00

// Check character: CRC-16-CCITT, preset to all ones
`define DSMW_CRC_POLY 16'h1021
`define DSMW_CRC_PRESET 16'hffff

// Data buffer shape
`define DSMW_BUF_DEPTH 2
`define DSMW_BYTE_W 8

`endif

// ===== hdl/dsmw_pkg.sv
// Types of the sector write encoder
`default_nettype none
package dsmw_pkg;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_PRE   = 3'b001,
      ST_SYNC  = 3'b010,
      ST_HDR   = 3'b011,
      ST_DATA  = 3'b100,
      ST_CRC   = 3'b101,
      ST_POST  = 3'b110,
      ST_FLUSH = 3'b111
   } dsmw_state_type;

   // Three-cell look window around the cell being written
   typedef struct packed {
      logic prev;
      logic cur;
      logic nxt;
   } dsmw_window_type;

   // Flux side outputs toward the drive write electronics
   typedef struct packed {
      logic gate;
      logic pulse;
      logic early;
      logic late;
   } dsmw_flux_type;

endpackage : dsmw_pkg
`default_nettype wire

// ===== hdl/dsmw_encoder.sv
// Sector formatter, CRC generator, MFM encoder and write pre-compensation
`timescale 1ns/1ps
`default_nettype none
`include "dsmw_cfg.svh"

module dsmw_encoder #(
   parameter int CELL_CYC = `DSMW_CELL_CYC,
   parameter int PRECOMP_CYC = `DSMW_PRECOMP_CYC,
   parameter int BUF_DEPTH = `DSMW_BUF_DEPTH
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Sector request
   input wire logic start_i,
   input wire logic [15:0] header_i,
   input wire logic inner_track_zone_flag_i,
   output logic busy_o,
   output logic done_o,
   output logic underrun_o,
   // Data byte stream from the controller
   input wire logic data_valid_i,
   input wire logic [7:0] data_i,
   output logic data_ready_o,
   // Drive write side
   output dsmw_pkg::dsmw_flux_type flux_o,
   output logic [15:0] sector_check_character_o
);

   localparam int MID_CYC = CELL_CYC / 2;
   localparam int CW = $clog2(CELL_CYC);
   localparam int PW = $clog2(BUF_DEPTH);

   // Shapes the cell counter and buffer pointers cannot serve
   if (CELL_CYC < 4 || PRECOMP_CYC < 1
       || PRECOMP_CYC >= MID_CYC) begin : g_bad_cell
      $error("dsmw_encoder: cell or shift count out of range");
   end
   if (BUF_DEPTH < 2
       || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0) begin : g_bad_buf
      $error("dsmw_encoder: buffer depth must be a power of two >= 2");
   end

   ////////////////////////////////////////////////////////////////////////
   // Data buffer: keeps words while the formatter is between byte loads

   logic [7:0] buf_mem_ff [BUF_DEPTH];
   logic [7:0] nxt_buf_mem [BUF_DEPTH];
   logic [PW-1:0] buf_wr_ff, nxt_buf_wr;
   logic [PW-1:0] buf_rd_ff, nxt_buf_rd;
   logic [PW:0] buf_cnt_ff, nxt_buf_cnt;
   logic buf_out_valid;
   logic buf_pop;
   logic buf_push;

   assign data_ready_o = (buf_cnt_ff != (PW+1)'(BUF_DEPTH));
   assign buf_out_valid = (buf_cnt_ff != '0);
   assign buf_push = data_valid_i && data_ready_o;

   always_comb begin
      nxt_buf_mem = buf_mem_ff;
      nxt_buf_wr = buf_wr_ff;
      nxt_buf_rd = buf_rd_ff;
      nxt_buf_cnt = buf_cnt_ff;
      if (buf_push) begin
         nxt_buf_mem[buf_wr_ff] = data_i;
         nxt_buf_wr = buf_wr_ff + 1'b1;
      end
      if (buf_pop) begin
         nxt_buf_rd = buf_rd_ff + 1'b1;
      end
      if (buf_push && !buf_pop) begin
         nxt_buf_cnt = buf_cnt_ff + 1'b1;
      end else if (!buf_push && buf_pop) begin
         nxt_buf_cnt = buf_cnt_ff - 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < BUF_DEPTH; i++) begin
            buf_mem_ff[i] <= 8'h00;
         end
         buf_wr_ff <= '0;
         buf_rd_ff <= '0;
         buf_cnt_ff <= '0;
      end else begin
         buf_mem_ff <= nxt_buf_mem;
         buf_wr_ff <= nxt_buf_wr;
         buf_rd_ff <= nxt_buf_rd;
         buf_cnt_ff <= nxt_buf_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sector formatter: one bit per cell into the look window

   dsmw_pkg::dsmw_state_type st_ff, nxt_st;
   logic [CW-1:0] cell_ff, nxt_cell;
   logic [8:0] byte_cnt_ff, nxt_byte_cnt;
   logic [2:0] bit_cnt_ff, nxt_bit_cnt;
   logic [7:0] sh_ff, nxt_sh;
   logic [15:0] hdr_ff, nxt_hdr;
   logic [15:0] crc_ff, nxt_crc;
   dsmw_pkg::dsmw_window_type win_ff, nxt_win;
   logic under_ff, nxt_under;
   logic done_ff, nxt_done;
   logic tick;
   logic [8:0] sec_len;
   logic [7:0] load_byte;
   logic out_bit;

   assign tick = (cell_ff == CW'(CELL_CYC - 1));
   assign busy_o = (st_ff != dsmw_pkg::ST_IDLE);
   assign done_o = done_ff;
   assign underrun_o = under_ff;
   assign sector_check_character_o = crc_ff;

   // A data byte is taken from the buffer at the first cell of each byte
   assign buf_pop = tick && (st_ff == dsmw_pkg::ST_DATA)
                    && (bit_cnt_ff == 3'd0) && buf_out_valid;

   always_comb begin
      unique case (st_ff)
         dsmw_pkg::ST_PRE: sec_len = `DSMW_PRE_LEN;
         dsmw_pkg::ST_SYNC: sec_len = `DSMW_SYNC_LEN;
         dsmw_pkg::ST_HDR: sec_len = `DSMW_HDR_LEN;
         dsmw_pkg::ST_DATA: sec_len = `DSMW_DATA_LEN;
         dsmw_pkg::ST_CRC: sec_len = `DSMW_CRC_LEN;
         dsmw_pkg::ST_POST: sec_len = `DSMW_POST_LEN;
         dsmw_pkg::ST_IDLE, dsmw_pkg::ST_FLUSH: sec_len = 9'd1;
      endcase
   end

   always_comb begin
      load_byte = `DSMW_FILL_BYTE;
      unique case (st_ff)
         dsmw_pkg::ST_SYNC: load_byte = `DSMW_SYNC_BYTE;
         dsmw_pkg::ST_HDR: begin
            load_byte = (byte_cnt_ff == 9'd0) ? hdr_ff[15:8] : hdr_ff[7:0];
         end
         // Underrun writes fill: the disc cannot wait for the controller
         dsmw_pkg::ST_DATA: begin
            load_byte = buf_out_valid ? buf_mem_ff[buf_rd_ff] : 8'h00;
         end
         dsmw_pkg::ST_CRC: begin
            load_byte = (byte_cnt_ff == 9'd0) ? crc_ff[15:8] : crc_ff[7:0];
         end
         dsmw_pkg::ST_IDLE, dsmw_pkg::ST_PRE, dsmw_pkg::ST_POST,
         dsmw_pkg::ST_FLUSH: load_byte = `DSMW_FILL_BYTE;
      endcase
      out_bit = (bit_cnt_ff == 3'd0) ? load_byte[7] : sh_ff[7];
   end

   always_comb begin
      nxt_st = st_ff;
      nxt_cell = cell_ff;
      nxt_byte_cnt = byte_cnt_ff;
      nxt_bit_cnt = bit_cnt_ff;
      nxt_sh = sh_ff;
      nxt_hdr = hdr_ff;
      nxt_crc = crc_ff;
      nxt_win = win_ff;
      nxt_under = under_ff;
      nxt_done = 1'b0;
      if (st_ff == dsmw_pkg::ST_IDLE) begin
         if (start_i) begin
            nxt_st = dsmw_pkg::ST_PRE;
            nxt_cell = '0;
            nxt_byte_cnt = 9'd0;
            nxt_bit_cnt = 3'd0;
            nxt_hdr = header_i;
            nxt_crc = `DSMW_CRC_PRESET;
            nxt_win = '0;
            nxt_under = 1'b0;
         end
      end else begin
         nxt_cell = tick ? '0 : cell_ff + 1'b1;
         if (tick) begin
            nxt_win.prev = win_ff.cur;
            nxt_win.cur = win_ff.nxt;
            nxt_win.nxt = (st_ff == dsmw_pkg::ST_FLUSH) ? 1'b0 : out_bit;
            if (st_ff == dsmw_pkg::ST_FLUSH) begin
               nxt_bit_cnt = bit_cnt_ff + 1'b1;
               if (bit_cnt_ff == `DSMW_FLUSH_CELLS - 3'd1) begin
                  nxt_st = dsmw_pkg::ST_IDLE;
                  nxt_done = 1'b1;
               end
            end else begin
               nxt_sh = (bit_cnt_ff == 3'd0) ? {load_byte[6:0], 1'b0}
                                             : {sh_ff[6:0], 1'b0};
               // Only data field bits enter the check register
               if (st_ff == dsmw_pkg::ST_DATA) begin
                  nxt_crc = {crc_ff[14:0], 1'b0}
                     ^ ((crc_ff[15] ^ out_bit) ? `DSMW_CRC_POLY
                                               : 16'h0000);
                  if (bit_cnt_ff == 3'd0 && !buf_out_valid) begin
                     nxt_under = 1'b1;
                  end
               end
               nxt_bit_cnt = bit_cnt_ff + 1'b1;
               if (bit_cnt_ff == 3'd7) begin
                  nxt_byte_cnt = byte_cnt_ff + 9'd1;
                  if (byte_cnt_ff == sec_len - 9'd1) begin
                     nxt_byte_cnt = 9'd0;
                     unique case (st_ff)
                        dsmw_pkg::ST_PRE: nxt_st = dsmw_pkg::ST_SYNC;
                        dsmw_pkg::ST_SYNC: nxt_st = dsmw_pkg::ST_HDR;
                        dsmw_pkg::ST_HDR: nxt_st = dsmw_pkg::ST_DATA;
                        dsmw_pkg::ST_DATA: nxt_st = dsmw_pkg::ST_CRC;
                        dsmw_pkg::ST_CRC: nxt_st = dsmw_pkg::ST_POST;
                        dsmw_pkg::ST_POST: nxt_st = dsmw_pkg::ST_FLUSH;
                        dsmw_pkg::ST_IDLE, dsmw_pkg::ST_FLUSH: nxt_st = st_ff;
                     endcase
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_ff <= dsmw_pkg::ST_IDLE;
         cell_ff <= '0;
         byte_cnt_ff <= 9'd0;
         bit_cnt_ff <= 3'd0;
         sh_ff <= 8'h00;
         hdr_ff <= 16'h0000;
         crc_ff <= `DSMW_CRC_PRESET;
         win_ff <= '0;
         under_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         cell_ff <= nxt_cell;
         byte_cnt_ff <= nxt_byte_cnt;
         bit_cnt_ff <= nxt_bit_cnt;
         sh_ff <= nxt_sh;
         hdr_ff <= nxt_hdr;
         crc_ff <= nxt_crc;
         win_ff <= nxt_win;
         under_ff <= nxt_under;
         done_ff <= nxt_done;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // MFM encoder with pre-compensation of data reversals

   dsmw_pkg::dsmw_flux_type flux_ff, nxt_flux;
   logic shift_early;
   logic shift_late;
   logic [CW-1:0] data_at;
   logic clock_rev;
   logic data_rev;

   assign flux_o = flux_ff;

   always_comb begin
      shift_early = inner_track_zone_flag_i
                    && win_ff.nxt && !win_ff.prev;
      shift_late = inner_track_zone_flag_i
                   && win_ff.prev && !win_ff.nxt;
      data_at = CW'(MID_CYC);
      if (shift_early) begin
         data_at = CW'(MID_CYC - PRECOMP_CYC);
      end else if (shift_late) begin
         data_at = CW'(MID_CYC + PRECOMP_CYC);
      end
      // Boundary reversal only between two zero cells
      clock_rev = (cell_ff == '0) && !win_ff.prev && !win_ff.cur;
      data_rev = win_ff.cur && (cell_ff == data_at);
      nxt_flux.gate = busy_o;
      nxt_flux.pulse = busy_o && (clock_rev || data_rev);
      nxt_flux.early = busy_o && win_ff.cur && shift_early;
      nxt_flux.late = busy_o && win_ff.cur && shift_late;
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flux_ff <= '0;
      end else begin
         flux_ff <= nxt_flux;
      end
   end

endmodule : dsmw_encoder
`default_nettype wire

// ===== verif/dsmw_enc_asserts.sv
// Port checker of the sector write encoder
`timescale 1ns/1ps
`default_nettype none
module dsmw_enc_asserts #(
   parameter int CELL_CYC = 400
) (
   // Clock, reset and request
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic start_i,
   input wire logic inner_track_zone_flag_i,
   input wire logic busy_o,
   input wire logic done_o,
   input wire logic underrun_o,
   // Byte stream and flux side
   input wire logic data_valid_i,
   input wire logic data_ready_o,
   input wire dsmw_pkg::dsmw_flux_type flux_o
);
   // 311 bytes of cells plus two flush cells, busy for whole cells
   localparam int unsigned SEC_CYC = 2490 * CELL_CYC;
   int unsigned cnt_ff;
   int unsigned nxt_cnt;
   always_comb nxt_cnt = busy_o ? cnt_ff + 1 : 0;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) cnt_ff <= 0;
      else cnt_ff <= nxt_cnt;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   sequence s_take;
      data_valid_i && data_ready_o && !busy_o;
   endsequence
   a_pulse_gated: assert property (flux_o.pulse |-> flux_o.gate)
      else $error("flux pulse outside write gate");
   a_pulse_gap: assert property (flux_o.pulse |=> !flux_o.pulse [*6])
      else $error("flux pulses too close");
   // Shift flags are registered, so they follow the flag one cycle late
   a_shift_zone: assert property ((flux_o.early || flux_o.late)
      |-> $past(inner_track_zone_flag_i)) else $error("shift outside zone");
   a_shift_excl: assert property (flux_o.early |-> !flux_o.late)
      else $error("early and late together");
   a_start_busy: assert property (start_i && !busy_o
      |=> busy_o && !underrun_o) else $error("start not taken");
   a_end_done: assert property ($fell(busy_o) |-> done_o)
      else $error("busy fell without done");
   a_sector_len: assert property (done_o
      |-> cnt_ff == SEC_CYC) else $error("bad length");
   a_done_pulse: assert property (done_o |=> !done_o)
      else $error("done held longer than one cycle");
   a_gate_busy: assert property (flux_o.gate == $past(busy_o))
      else $error("write gate does not follow busy");
   a_buf_full: assert property (s_take ##1 s_take |=> !data_ready_o)
      else $error("buffer took a third byte");
endmodule : dsmw_enc_asserts
bind dsmw_encoder dsmw_enc_asserts #(.CELL_CYC(CELL_CYC)) chk_u (
   .clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_i),
   .inner_track_zone_flag_i(inner_track_zone_flag_i),
   .busy_o(busy_o), .done_o(done_o), .underrun_o(underrun_o),
   .data_valid_i(data_valid_i), .data_ready_o(data_ready_o),
   .flux_o(flux_o)
);
`default_nettype wire

// ===== verif/dsmw_drive_model.sv
// Drive write side model: turns flux pulses back into bit cells
`timescale 1ns/1ps
`default_nettype none
module dsmw_drive_model #(
   parameter int CELL_CYC = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Encoder write side
   input wire dsmw_pkg::dsmw_flux_type flux_i,
   // One decoded cell per cell time
   output logic cell_v_o,
   output logic cell_bit_o,
   output logic cell_clk_o,
   output logic [7:0] cell_off_o,
   output logic [1:0] cell_shift_o
);
   logic on_ff, bit_ff, clk_ff;
   logic [7:0] off_ff;
   logic [1:0] sh_ff;
   int t_ff;
   // Phase comes from the first pulse, always a clock reversal
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         on_ff <= 1'b0;
         cell_v_o <= 1'b0;
      end else begin
         cell_v_o <= 1'b0;
         t_ff <= t_ff + 1;
         if (!flux_i.gate) on_ff <= 1'b0;
         else if (!on_ff && flux_i.pulse) begin
            on_ff <= 1'b1;
            t_ff <= 1;
            {clk_ff, bit_ff, off_ff, sh_ff} <= {1'b1, 11'h000};
         end else if (on_ff) begin
            if (flux_i.pulse && t_ff % CELL_CYC == 0) clk_ff <= 1'b1;
            else if (flux_i.pulse) begin
               bit_ff <= 1'b1;
               off_ff <= 8'(t_ff % CELL_CYC);
               sh_ff <= {flux_i.early, flux_i.late};
            end
            if (t_ff % CELL_CYC == CELL_CYC - 1) begin
               cell_v_o <= 1'b1;
               {cell_clk_o, cell_bit_o} <= {clk_ff, bit_ff};
               {cell_off_o, cell_shift_o} <= {off_ff, sh_ff};
               {clk_ff, bit_ff, off_ff, sh_ff} <= 12'h000;
            end
         end
      end
   end
endmodule : dsmw_drive_model
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench of the sector write encoder
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int CELL = 8;
   logic clk_i = 0, rstn_i = 0, start_i = 0, zone = 0, data_valid_i = 0;
   logic [7:0] data_i = 8'h00;
   logic [15:0] header_i = 16'h0000;
   logic busy_o, done_o, underrun_o, data_ready_o, cv, cb, cc;
   logic [7:0] coff;
   logic [1:0] csh;
   logic [15:0] crc_o;
   dsmw_pkg::dsmw_flux_type flux_o;
   int num_errors = 0, checks_done = 0, cyc = 0;
   logic bits[$], clks[$];
   logic [7:0] offs[$];
   logic [1:0] shs[$];
   dsmw_encoder #(.CELL_CYC(CELL), .PRECOMP_CYC(1)) dut_u (
      .clk_i(clk_i), .rstn_i(rstn_i), .start_i(start_i),
      .header_i(header_i), .inner_track_zone_flag_i(zone),
      .busy_o(busy_o), .done_o(done_o), .underrun_o(underrun_o),
      .data_valid_i(data_valid_i), .data_i(data_i),
      .data_ready_o(data_ready_o), .flux_o(flux_o),
      .sector_check_character_o(crc_o)
   );
   dsmw_drive_model #(.CELL_CYC(CELL)) drv_u (
      .clk_i(clk_i), .rstn_i(rstn_i), .flux_i(flux_o), .cell_v_o(cv),
      .cell_bit_o(cb), .cell_clk_o(cc), .cell_off_o(coff),
      .cell_shift_o(csh)
   );
   initial forever #2.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      if (cv === 1'b1) begin
         bits.push_back(cb);
         clks.push_back(cc);
         offs.push_back(coff);
         shs.push_back(csh);
      end
      if (++cyc == 90000) begin
         num_errors++;
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done
   task automatic check(input logic [31:0] got, exp, input string m);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s %h %h", $time, m, got, exp);
      end
   endtask : check
   function automatic logic [15:0] crc_upd(logic [15:0] c, logic [7:0] b);
      for (int k = 7; k >= 0; k--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ b[k]) ? 16'h1021 : 16'h0000);
      return c;
   endfunction : crc_upd
   task automatic send_byte(input logic [7:0] b);
      data_i = b;
      data_valid_i = 1'b1;
      while (data_ready_o !== 1'b1) @(posedge clk_i) #1;
      @(posedge clk_i) #1;
   endtask : send_byte
   ////////////////////////////////////////////////////////////////////////
   // Whole sector; without feed every data byte underruns and is zero
   task automatic sector(input logic [15:0] hdr, input logic z, input bit feed);
      logic [7:0] d[256];
      logic [15:0] crc;
      logic [1:0] sh;
      logic e[$];
      int s, n;
      crc = 16'hffff;
      foreach (d[i]) begin
         d[i] = feed ? 8'(i * 37 + hdr[7:0]) : 8'h00;
         crc = crc_upd(crc, d[i]);
      end
      for (int i = 15; i >= 0; i--) e.push_back(hdr[i]);
      foreach (d[i]) for (int k = 7; k >= 0; k--) e.push_back(d[i][k]);
      for (int i = 15; i >= 0; i--) e.push_back(crc[i]);
      repeat (144) e.push_back(1'b0);
      bits.delete();
      clks.delete();
      offs.delete();
      shs.delete();
      if (feed) begin
         send_byte(d[0]);
         send_byte(d[1]);
         check(data_ready_o, 0, "full");
         data_valid_i = 1'b0;
      end
      {header_i, zone, start_i} = {hdr, z, 1'b1};
      @(posedge clk_i) #1;
      check(busy_o, 1, "busy");
      // A second start while busy must not restart or relatch the header
      header_i = ~hdr;
      @(posedge clk_i) #1 start_i = 1'b0;
      n = 0;
      fork
         if (feed) begin
            for (int i = 2; i < 256; i++) send_byte(d[i]);
            data_valid_i = 1'b0;
         end
         while (done_o !== 1'b1 && n < 30000) begin
            @(posedge clk_i) #1;
            n++;
         end
      join
      check(done_o, 1, "done");
      check(underrun_o, !feed, "underrun");
      check(crc_o, crc, "check word");
      repeat (2 * CELL) @(posedge clk_i);
      #1;
      s = 0;
      while (s < bits.size() && bits[s] !== 1'b1) s++;
      // Sync one is stream bit 263, behind two zero lead-in cells
      check(s, 265, "preamble");
      foreach (e[i]) check(bits[s + 1 + i], e[i], "bit");
      for (int i = 1; i + 1 < bits.size(); i++) begin
         check(clks[i], !bits[i - 1] && !bits[i], "clock");
         if (bits[i]) begin
            sh = {!bits[i - 1] && bits[i + 1], bits[i - 1] && !bits[i + 1]};
            sh = z ? sh : 2'b00;
            check(offs[i], CELL / 2 - sh[1] + sh[0], "place");
            check(shs[i], sh, "shift");
         end
      end
   endtask : sector
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge clk_i);
      check({busy_o, done_o, underrun_o, data_ready_o, flux_o}, 8'h10, "rst");
      check(crc_o, 16'hffff, "rst crc");
      #1 rstn_i = 1'b1;
      sector(16'h2a5c, 1'b0, 1'b1);
      sector(16'h8113, 1'b1, 1'b1);
      sector(16'h0f0f, 1'b1, 1'b0);
      test_done();
   end
endmodule : tb
`default_nettype wire
